/* File: design/lcr_rx.sv */
`include "lcr_cfg.svh"

module lcr_rx #(
  parameter int RAM_DEPTH = `LCR_RAM_DEPTH
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       address_lsb_strap_in,
  input  wire logic       hw_subaddr_bit0_in,
  input  wire logic       hw_subaddr_bit1_in,
  input  wire logic       hw_subaddr_bit2_in,
  input  wire logic [5:0] ram_rd_addr_in,
  output logic      [3:0] ram_rd_data_out,
  output logic            cmd_valid_out,
  output logic      [2:0] cmd_type_out,
  output logic      [7:0] cmd_byte_out,
  output logic      [1:0] drive_mode_out,
  output logic            bias_out,
  output logic            display_en_out,
  output logic            power_save_out,
  output logic            in_bank_out,
  output logic            out_bank_out,
  output logic            blink_alt_out,
  output logic      [1:0] blink_freq_out,
  output logic      [5:0] data_ptr_out,
  output logic      [2:0] subaddr_cnt_out,
  output logic            bus_busy_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (RAM_DEPTH < 2 || RAM_DEPTH > 64)
  begin : g_chk
    $error("lcr_rx: RAM_DEPTH must lie in 2..64");
  end

  localparam logic [5:0] PTR_LAST = 6'(RAM_DEPTH - 1);

  // ----------------------------------------------------------------
  // Fill helpers
  // ----------------------------------------------------------------
  // Bits of one byte taken per display word
  function automatic logic [2:0] lcr_bpw(input logic [1:0] md);
    logic [2:0] n;
    n = 3'h4;
    unique case (md)
      `LCR_MODE_STATIC: n = 3'h1;
      `LCR_MODE_MUX2:   n = 3'h2;
      `LCR_MODE_MUX3:   n = 3'h3;
      `LCR_MODE_MUX4:   n = 3'h4;
    endcase
    return n;
  endfunction

  // Words written per byte in each mode
  function automatic logic [3:0] lcr_words(input logic [1:0] md);
    logic [3:0] n;
    n = 4'h2;
    unique case (md)
      `LCR_MODE_STATIC: n = 4'h8;
      `LCR_MODE_MUX2:   n = 4'h4;
      `LCR_MODE_MUX3:   n = 4'h3;
      `LCR_MODE_MUX4:   n = 4'h2;
    endcase
    return n;
  endfunction

  // Mask and data of the word now at the head of the byte
  function automatic logic [7:0] lcr_fill(input logic [1:0] md,
                                          input logic       ib,
                                          input logic [7:0] b,
                                          input logic       last);
    logic [3:0] m;
    logic [3:0] w;
    w = {b[4], b[5], b[6], b[7]};
    m = 4'hf;
    unique case (md)
      `LCR_MODE_STATIC: m = 4'h1;
      `LCR_MODE_MUX2:   m = 4'h3;
      `LCR_MODE_MUX3:   m = last ? 4'h3 : 4'h7;
      `LCR_MODE_MUX4:   m = 4'hf;
    endcase
    // Alternate bank only exists in static and 1:2 modes
    if (ib && (md == `LCR_MODE_STATIC || md == `LCR_MODE_MUX2))
    begin
      m = {m[1:0], 2'h0};
      w = {w[1:0], 2'h0};
    end
    return {m, w};
  endfunction

  // Five command kinds from the opcode bits
  function automatic lcr_pkg::lcr_cmd_t lcr_decode(input logic [7:0] b);
    lcr_pkg::lcr_cmd_t c;
    c = lcr_pkg::cmd_none;
    if (!b[6])
      c = lcr_pkg::cmd_load_ptr;
    else if (!b[5])
      c = lcr_pkg::cmd_mode_set;
    else if (b[4:3] == 2'h0)
      c = lcr_pkg::cmd_dev_sel;
    else if (b[4:3] == 2'h2)
      c = lcr_pkg::cmd_blink;
    else if (b[4:2] == 3'h6)
      c = lcr_pkg::cmd_bank_sel;
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  logic link_bit_q;
  logic link_tog_q;

  // Data is stable while clock is high, so the rising edge takes it;
  // the toggle tells the core a new bit waits, and the bit holds
  // until the next rise, long after the core has read it.
  // Link clock stops when idle, so reset cannot wait for its edge.
  always_ff @(posedge link_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      link_bit_q <= 1'b0;
      link_tog_q <= 1'b0;
    end
    else
    begin
      link_bit_q <= sda_in;
      link_tog_q <= ~link_tog_q;
    end
  end

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  lcr_pkg::lcr_core_t q;
  lcr_pkg::lcr_core_t d;
  logic               start;
  logic               stop;
  logic               bit_ev;
  logic               byte_done;
  logic [7:0]         nb;
  logic [2:0]         hw;
  logic               addr_hit;
  logic               sub_hit;

  // Conditions seen on synchronised lines
  assign start     = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
  assign stop      = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
  assign bit_ev    = q.tog_s != q.tog_p;
  assign byte_done = bit_ev && q.bit_cnt == `LCR_LAST_BIT;
  assign nb        = {q.sh[6:0], link_bit_q};
  assign hw        = q.strap_s[2:0];
  assign sub_hit   = q.sub == hw;
  assign addr_hit  = nb[7:1] == {`LCR_ADDR_HI, q.strap_s[3]};

  // Next state of the parser, acknowledge, stretch and write engine
  always_comb
  begin
    logic [7:0] fw;
    fw = lcr_fill(q.mode, q.ibank, q.wbuf, q.wcnt == 4'h1);
    d = q;
    d.cmd_v = 1'b0;
    d.we = 1'b0;
    d.sda_m = sda_in;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.scl_m = scl_in;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.tog_m = link_tog_q;
    d.tog_s = q.tog_m;
    d.tog_p = q.tog_s;
    d.strap_m = {address_lsb_strap_in, hw_subaddr_bit2_in,
                 hw_subaddr_bit1_in, hw_subaddr_bit0_in};
    d.strap_s = q.strap_m;
    // Outside START and STOP, drive or release data only while clock is low
    if (!q.scl_s)
    begin
      d.ack_drv = q.ack_q;
    end
    // One display word per cycle; gated store, pointer always moves
    if (q.busy)
    begin
      d.we = sub_hit;
      d.wa = q.ptr;
      d.wm = fw[7:4];
      d.wd = fw[3:0];
      d.wbuf = q.wbuf << lcr_bpw(q.mode);
      d.wcnt = q.wcnt - 4'h1;
      d.busy = q.wcnt != 4'h1;
      if (q.ptr == PTR_LAST)
      begin
        d.ptr = 6'h0;
        d.sub = q.sub + 3'h1;
      end
      else
      begin
        d.ptr = q.ptr + 6'h1;
      end
    end
    // Hold clock low while storing in power-saving mode, so a fast master cannot overrun
    d.stretch = d.busy && q.lp && (q.stretch || !q.scl_s);
    // Bit and byte framing
    if (bit_ev && q.bit_cnt == `LCR_ACK_SLOT)
    begin
      d.bit_cnt = 4'h0;
      d.ack_q = 1'b0;
    end
    else if (bit_ev)
    begin
      d.sh = nb;
      d.bit_cnt = q.bit_cnt + 4'h1;
    end
    if (byte_done)
    begin
      unique case (q.st)
        lcr_pkg::st_addr:
        begin
          // Reads are never served: only a write address is taken
          if (addr_hit && !nb[0])
          begin
            d.ack_q = 1'b1;
            d.st = lcr_pkg::st_cmd;
          end
          else
          begin
            d.st = lcr_pkg::st_ign;
          end
        end
        lcr_pkg::st_cmd:
        begin
          d.ack_q = 1'b1;
          d.cmd_v = 1'b1;
          d.cmd_t = lcr_decode(nb);
          d.cmd_b = nb;
          unique case (lcr_decode(nb))
            lcr_pkg::cmd_mode_set:
            begin
              d.mode = nb[1:0];
              d.bias = nb[`LCR_CMD_BIAS];
              d.en = nb[`LCR_CMD_EN];
              d.lp = nb[`LCR_CMD_LP];
            end
            lcr_pkg::cmd_load_ptr: d.ptr = nb[5:0];
            lcr_pkg::cmd_dev_sel:  d.sub = nb[2:0];
            lcr_pkg::cmd_bank_sel:
            begin
              d.ibank = nb[`LCR_CMD_IBANK];
              d.obank = nb[`LCR_CMD_OBANK];
            end
            lcr_pkg::cmd_blink:
            begin
              d.blink_a = nb[`LCR_CMD_BLINK_A];
              d.bf = nb[1:0];
            end
            lcr_pkg::cmd_none: d.cmd_v = 1'b1;
          endcase
          if (!nb[`LCR_CONT_BIT])
          begin
            d.st = lcr_pkg::st_data;
          end
        end
        lcr_pkg::st_data:
        begin
          // No byte limit: data state lasts until STOP or a repeated START
          d.ack_q = sub_hit;
          d.wbuf = nb;
          d.wcnt = lcr_words(q.mode);
          d.busy = 1'b1;
        end
        default: d.ack_q = 1'b0;
      endcase
    end
    // Any START restarts the parser at the address byte
    if (start)
    begin
      d.st = lcr_pkg::st_addr;
      d.bit_cnt = 4'h0;
      d.ack_q = 1'b0;
      d.ack_drv = 1'b0;
    end
    if (stop)
    begin
      d.st = lcr_pkg::st_idle;
      d.ack_q = 1'b0;
      d.ack_drv = 1'b0;
    end
    if (reset_in)
    begin
      d = '0;
      d.mode = `LCR_RST_MODE;
    end
  end

  // Single state register
  always_ff @(posedge clk_in)
  begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Display memory
  // ----------------------------------------------------------------
  lcr_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (6),
    .DW    (4)
  ) u_ram (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .we_in    (q.we),
    .wa_in    (q.wa),
    .wd_in    (q.wd),
    .wm_in    (q.wm),
    .ra_in    (ram_rd_addr_in),
    .rd_out   (ram_rd_data_out)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain lines only ever pull low
  assign sda_out         = 1'b0;
  assign scl_out         = 1'b0;
  assign sda_oe_out      = q.ack_drv;
  assign scl_oe_out      = q.stretch;
  assign cmd_valid_out   = q.cmd_v;
  assign cmd_type_out    = q.cmd_t;
  assign cmd_byte_out    = q.cmd_b;
  assign drive_mode_out  = q.mode;
  assign bias_out        = q.bias;
  assign display_en_out  = q.en;
  assign power_save_out  = q.lp;
  assign in_bank_out     = q.ibank;
  assign out_bank_out    = q.obank;
  assign blink_alt_out   = q.blink_a;
  assign blink_freq_out  = q.bf;
  assign data_ptr_out    = q.ptr;
  assign subaddr_cnt_out = q.sub;
  assign bus_busy_out    = q.st != lcr_pkg::st_idle;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_cmd_byte;
    byte_done && q.st == lcr_pkg::st_cmd;
  endsequence

  sequence s_data_byte;
    byte_done && q.st == lcr_pkg::st_data;
  endsequence

  AST_IDLE_QUIET: assert property (
    !bus_busy_out |-> !sda_oe_out)
    else $error("data driven while bus idle");

  AST_START_PARSE: assert property (
    start |=> q.st == lcr_pkg::st_addr && q.bit_cnt == 4'h0)
    else $error("start did not reset parser");

  AST_STOP_END: assert property (
    stop |=> !bus_busy_out && !sda_oe_out)
    else $error("stop did not end transfer");

  AST_ACK_HOLD: assert property (
    q.scl_s && $past(q.scl_s) && !$past(start) && !$past(stop)
      |-> $stable(sda_oe_out))
    else $error("data line changed while clock high");

  AST_ADDR_MISS: assert property (
    byte_done && q.st == lcr_pkg::st_addr && !addr_hit
      |=> q.st == lcr_pkg::st_ign && !q.ack_q)
    else $error("foreign address not ignored");

  AST_IGN_SILENT: assert property (
    q.st == lcr_pkg::st_ign |-> !q.ack_q && !q.busy)
    else $error("ignored transfer produced activity");

  AST_CMD_ACK: assert property (
    s_cmd_byte |=> q.ack_q && cmd_valid_out)
    else $error("command byte not acknowledged");

  AST_CONT_END: assert property (
    s_cmd_byte ##0 !nb[7] |=> q.st == lcr_pkg::st_data)
    else $error("cleared continuation did not end commands");

  AST_DATA_ACK: assert property (
    s_data_byte |=> q.ack_q == $past(sub_hit))
    else $error("data acknowledge wrong for subaddress");

  AST_FILL_MUX4: assert property (
    s_data_byte ##0 q.mode == `LCR_MODE_MUX4
      |=> q.busy [*2] ##1 !q.busy)
    else $error("1:4 byte did not take two words");

  AST_SUB_GATE: assert property (
    q.busy && !sub_hit |=> !q.we)
    else $error("store not suppressed on mismatch");

  AST_STRETCH_LP: assert property (
    scl_oe_out |-> power_save_out && q.busy)
    else $error("clock held outside power-saving store");

endmodule

/* File: design/lcr_cfg.svh */
`ifndef LCR_CFG_SVH
`define LCR_CFG_SVH

// ----------------------------------------------------------------
// Serial link framing
// ----------------------------------------------------------------
`define LCR_ADDR_HI     6'h1c
`define LCR_LAST_BIT    4'h7
`define LCR_ACK_SLOT    4'h8
`define LCR_CONT_BIT    7

// ----------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------
`define LCR_CMD_LP      4
`define LCR_CMD_EN      3
`define LCR_CMD_BIAS    2
`define LCR_CMD_IBANK   1
`define LCR_CMD_OBANK   0
`define LCR_CMD_BLINK_A 2

// ----------------------------------------------------------------
// Drive modes and reset values
// ----------------------------------------------------------------
`define LCR_MODE_STATIC 2'h1
`define LCR_MODE_MUX2   2'h2
`define LCR_MODE_MUX3   2'h3
`define LCR_MODE_MUX4   2'h0
`define LCR_RST_MODE    2'h1
`define LCR_RAM_DEPTH   40

`endif

/* File: design/lcr_pkg.sv */
package lcr_pkg;

  // ----------------------------------------------------------------
  // Parser states and command kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_cmd,
    st_data,
    st_ign
  } lcr_state_t;

  typedef enum logic [2:0] {
    cmd_none,
    cmd_mode_set,
    cmd_load_ptr,
    cmd_dev_sel,
    cmd_bank_sel,
    cmd_blink
  } lcr_cmd_t;

  // ----------------------------------------------------------------
  // Whole state of the receiver core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sda_m, sda_s, sda_p;
    logic       scl_m, scl_s, scl_p;
    logic       tog_m, tog_s, tog_p;
    logic [3:0] strap_m, strap_s;
    lcr_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic       ack_q, ack_drv, stretch;
    logic [1:0] mode;
    logic       lp, en, bias, ibank, obank, blink_a;
    logic [1:0] bf;
    logic [5:0] ptr;
    logic [2:0] sub;
    logic [7:0] wbuf;
    logic [3:0] wcnt;
    logic       busy, we;
    logic [5:0] wa;
    logic [3:0] wd, wm;
    logic       cmd_v;
    lcr_cmd_t   cmd_t;
    logic [7:0] cmd_b;
  } lcr_core_t;

endpackage

/* File: design/lcr_ram.sv */
`include "lcr_cfg.svh"

module lcr_ram #(
  parameter int DEPTH = `LCR_RAM_DEPTH,
  parameter int AW    = 6,
  parameter int DW    = 4
) (
  input  wire logic          clk_in,
  input  wire logic          reset_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] wa_in,
  input  wire logic [DW-1:0] wd_in,
  input  wire logic [DW-1:0] wm_in,
  input  wire logic [AW-1:0] ra_in,
  output logic      [DW-1:0] rd_out
);

  logic [DW-1:0] mem [DEPTH];

  // Address width must reach every word
  if (DEPTH > (1 << AW) || DEPTH < 1)
  begin : g_chk
    $error("lcr_ram: DEPTH does not fit AW");
  end

  // Masked write keeps untouched bit planes; read data is registered
  always_ff @(posedge clk_in)
  begin
    if (we_in && int'(wa_in) < DEPTH)
    begin
      mem[wa_in] <= (mem[wa_in] & ~wm_in) | (wd_in & wm_in);
    end
    if (reset_in || int'(ra_in) >= DEPTH)
    begin
      rd_out <= '0;
    end
    else
    begin
      rd_out <= mem[ra_in];
    end
  end

endmodule

/* File: bench/lcr_master_model.sv */
// ----------------------------------------------------------------
// Two-wire bus master driving the receiver through open-drain pins
// ----------------------------------------------------------------
module lcr_master_model #(
  parameter int HALF_NS = 303
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe_out,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half period in use; the bench shortens it to provoke a clock hold
  int half_ns = HALF_NS;

  // Both lines released: the bus idles high and the clock stands still
  initial
  begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end

  // Release the clock and wait out a stretch, bounded so a stuck
  // low clock cannot hang the model forever
  task automatic free_clock();
    int n;
    n = 0;
    scl_oe_out = 1'b0;
    while (scl_in !== 1'b1 && n < 4000)
    begin
      #10;
      n++;
    end
  endtask

  // Data moves only mid-way through the low phase, clear of the
  // receiver's synchronised clock edges
  task automatic pulse(input logic b, output logic seen);
    #(half_ns / 2);
    sda_oe_out = ~b;
    #(half_ns / 2);
    free_clock();
    #(half_ns / 2);
    seen = sda_in;
    #(half_ns / 2);
    scl_oe_out = 1'b1;
  endtask

  // Eight bits, MSB first, then a released acknowledge slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask

  // Works from idle and as a repeated start
  task automatic bus_start();
    #(half_ns / 2);
    sda_oe_out = 1'b0;
    #(half_ns / 2);
    free_clock();
    #(half_ns);
    sda_oe_out = 1'b1;
    #(half_ns);
    scl_oe_out = 1'b1;
  endtask

  task automatic bus_stop();
    #(half_ns / 2);
    sda_oe_out = 1'b1;
    #(half_ns / 2);
    free_clock();
    #(half_ns);
    sda_oe_out = 1'b0;
    #(half_ns);
  endtask
endmodule

/* File: bench/test_lcd_i2c_command_receiver.sv */
module test_lcd_i2c_command_receiver;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Design, master and open-drain wires
  // ----------------------------------------------------------------
  localparam int         DEPTH  = 40;
  localparam logic [2:0] HW_SUB = 3'h5;
  logic       clk_in, reset_in, strap, m_scl_oe, m_sda_oe, scl_w, sda_w;
  logic       d_sda, d_sda_oe, d_scl, d_scl_oe, cmd_valid_out;
  logic       bias_out, display_en_out, power_save_out, in_bank_out;
  logic       out_bank_out, blink_alt_out, bus_busy_out;
  logic [5:0] ram_rd_addr_in, data_ptr_out;
  logic [3:0] ram_rd_data_out;
  logic [2:0] cmd_type_out, subaddr_cnt_out;
  logic [7:0] cmd_byte_out;
  logic [1:0] drive_mode_out, blink_freq_out;
  int         errors, check_count, cycles, pulses, exp_pulses, stretches;
  // Model state
  logic [5:0] ptr;
  logic [2:0] sub, ct;
  logic [7:0] cb;
  logic [1:0] mode, bf;
  logic       lp, en, bias, ib, ob, ba;
  logic [3:0] mem [DEPTH];

  // Pull-ups: a line is low only while some party pulls it
  assign scl_w = ~(m_scl_oe | d_scl_oe);
  assign sda_w = ~(m_sda_oe | d_sda_oe);

  // Link half period kept long: the receiver samples the wire
  // through synchronisers on the system clock
  lcr_master_model #(.HALF_NS(303)) i_master (
    .scl_in(scl_w), .sda_in(sda_w),
    .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe));

  lcr_rx #(.RAM_DEPTH(DEPTH)) i_dut (
    .clk_in(clk_in), .reset_in(reset_in), .link_clk_in(scl_w),
    .scl_in(scl_w), .sda_in(sda_w), .sda_out(d_sda),
    .sda_oe_out(d_sda_oe), .scl_out(d_scl), .scl_oe_out(d_scl_oe),
    .address_lsb_strap_in(strap), .hw_subaddr_bit0_in(HW_SUB[0]),
    .hw_subaddr_bit1_in(HW_SUB[1]), .hw_subaddr_bit2_in(HW_SUB[2]),
    .ram_rd_addr_in(ram_rd_addr_in), .ram_rd_data_out(ram_rd_data_out),
    .cmd_valid_out(cmd_valid_out), .cmd_type_out(cmd_type_out),
    .cmd_byte_out(cmd_byte_out), .drive_mode_out(drive_mode_out),
    .bias_out(bias_out), .display_en_out(display_en_out),
    .power_save_out(power_save_out), .in_bank_out(in_bank_out),
    .out_bank_out(out_bank_out), .blink_alt_out(blink_alt_out),
    .blink_freq_out(blink_freq_out), .data_ptr_out(data_ptr_out),
    .subaddr_cnt_out(subaddr_cnt_out), .bus_busy_out(bus_busy_out));

  always #12.5 clk_in = ~clk_in;

  // Cycle ceiling cuts a hang short; command pulses are counted
  always @(posedge clk_in)
  begin
    cycles++;
    if (!reset_in && cmd_valid_out === 1'b1)
      pulses++;
    // Cycles in which the receiver holds the clock line low
    if (!reset_in && d_scl_oe === 1'b1)
      stretches++;
    if (cycles == 40000)
    begin
      errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Checking and transfer tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_state();
    check({cmd_type_out, cmd_byte_out, drive_mode_out, bias_out,
           display_en_out, power_save_out, in_bank_out, out_bank_out,
           blink_alt_out, blink_freq_out, data_ptr_out, subaddr_cnt_out},
          {ct, cb, mode, bias, en, lp, ib, ob, ba, bf, ptr, sub});
  endtask

  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    logic ack;
    i_master.send_byte(b, ack);
    @(posedge clk_in);
    #1;
    check(ack, exp_ack);
    check_state();
  endtask

  task automatic open_frame(input logic [7:0] a, input logic exp_ack);
    i_master.bus_start();
    @(posedge clk_in);
    #1;
    check(bus_busy_out, 1'b1);
    xfer(a, exp_ack);
  endtask

  task automatic close_frame();
    i_master.bus_stop();
    repeat (2) @(posedge clk_in);
    #1;
    check(bus_busy_out, 1'b0);
    check({d_sda, d_scl}, 2'h0);
  endtask

  // Model decode mirrors the command table; undefined codes change nothing
  task automatic cmd(input logic [7:0] b);
    exp_pulses++;
    cb = b;
    if (b[6] == 1'b0)
      {ct, ptr} = {lcr_pkg::cmd_load_ptr, b[5:0]};
    else if (b[6:5] == 2'b10)
      {ct, lp, en, bias, mode} = {lcr_pkg::cmd_mode_set, b[4:0]};
    else if (b[6:3] == 4'b1100)
      {ct, sub} = {lcr_pkg::cmd_dev_sel, b[2:0]};
    else if (b[6:2] == 5'b11110)
      {ct, ib, ob} = {lcr_pkg::cmd_bank_sel, b[1:0]};
    else if (b[6:3] == 4'b1110)
      {ct, ba, bf} = {lcr_pkg::cmd_blink, b[2:0]};
    else
      ct = lcr_pkg::cmd_none;
    xfer(b, 1'b1);
  endtask

  // Fill order per mode: bits per word n, first bit into the low bit
  task automatic data(input logic [7:0] b);
    int  n, base;
    logic hit;
    n = (mode == 2'h0) ? 4 : int'(mode);
    base = (ib && n <= 2) ? 2 : 0;
    hit = (sub == HW_SUB);
    for (int k = 0; k < 8; k++)
    begin
      // Gate per word: a wrap inside a byte hands over to the next device
      if (sub == HW_SUB)
        mem[ptr][base + k % n] = b[7 - k];
      if (k % n == n - 1 || k == 7)
        {sub, ptr} = (ptr == DEPTH - 1) ? {sub + 3'h1, 6'h0}
                                        : {sub, ptr + 6'h1};
    end
    xfer(b, hit);
  endtask

  task automatic check_ram();
    for (int a = 0; a < DEPTH; a++)
    begin
      ram_rd_addr_in = a[5:0];
      @(posedge clk_in);
      #1;
      check(ram_rd_data_out, mem[a]);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d, check_count %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    strap = 1'b0;
    ram_rd_addr_in = 6'h0;
    {errors, check_count, cycles, pulses, exp_pulses, stretches} = '0;
    {ptr, sub, ct, cb, bf, lp, en, bias, ib, ob, ba} = '0;
    mode = 2'h1;
    void'($urandom(32'h51c38728));
    repeat (6) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    check_state();
    // Other address level and a read request: both ignored to STOP
    open_frame(8'h72, 1'b0);
    xfer(8'h48, 1'b0);
    close_frame();
    strap = 1'b1;
    repeat (4) @(posedge clk_in);
    open_frame(8'h73, 1'b0);
    close_frame();
    // Fill the whole memory in 1:4 mode, ending on the last word so the pointer wraps and the counter moves on
    open_frame(8'h72, 1'b1);
    cmd(8'hc8);
    cmd(8'he5);
    cmd(8'h00);
    repeat (20) data($urandom_range(0, 255));
    close_frame();
    check_ram();
    // Counter now past this device: data refused, pointer still moves
    open_frame(8'h72, 1'b1);
    cmd(8'h14);
    data(8'ha5);
    // Every drive mode, each behind a repeated start
    for (int m = 1; m < 5; m++)
    begin
      // Static power-saving store outlasts a fast clock high phase
      i_master.half_ns = (m == 1) ? 150 : 303;
      stretches = 0;
      open_frame(8'h72, 1'b1);
      cmd({3'b110, m[0], 2'b11, m[1:0]});
      cmd(8'he8);
      cmd({6'b111110, 2'($urandom_range(0, 3))});
      cmd({5'b11110, 3'($urandom_range(0, 7))});
      cmd(8'he5);
      cmd({2'b00, 6'($urandom_range(0, 30))});
      repeat (2) data($urandom_range(0, 255));
      check(stretches != 0, m == 1);
    end
    close_frame();
    check_ram();
    check(pulses, exp_pulses);
    complete_run();
  end
endmodule
